// *** include/otlm_map.svh ***
// Command bytes, field positions, reset values and fixed codes of the over-temperature register bank.
`ifndef OTLM_MAP_SVH
`define OTLM_MAP_SVH

`define OTLM_CMD_FIRST_MASK        8'h0C
`define OTLM_CMD_SECOND_MASK       8'h0D
`define OTLM_CMD_THIRD_MASK        8'h0E
`define OTLM_CMD_LOCAL_LIMIT       8'h40
`define OTLM_CMD_R1_FIRST_LIMIT    8'h41
`define OTLM_CMD_R2_FIRST_LIMIT    8'h42
`define OTLM_CMD_R1_SHARED_LIMIT   8'h49
`define OTLM_CMD_R2_SHARED_LIMIT   8'h4A
`define OTLM_CMD_HYSTERESIS        8'h5A
`define OTLM_CMD_MAKER_ID          8'hFE
`define OTLM_CMD_DIE_REV           8'hFF

`define OTLM_RST_FIRST_MASK        8'h01
`define OTLM_RST_SECOND_MASK       8'h00
`define OTLM_RST_THIRD_MASK        8'h07
`define OTLM_RST_LOCAL_LIMIT       8'h55
`define OTLM_RST_FIRST_LIMIT       8'h6E
`define OTLM_RST_SHARED_LIMIT      8'h55
`define OTLM_RST_HYSTERESIS        8'h0A

`define OTLM_MASK_BITS             8'h07
`define OTLM_LOCAL_LIMIT_BITS      8'h7F
`define OTLM_HYST_BITS             8'h1F
`define OTLM_READ_UNMAPPED         8'h00

`define OTLM_BIT_LOCAL             0
`define OTLM_BIT_REMOTE_ONE        1
`define OTLM_BIT_REMOTE_TWO        2

`define OTLM_HYST_WIDTH            5
`define OTLM_NUM_CHANNELS          5

`endif

// *** include/otlm_pkg.sv ***
// Types shared by the over-temperature register bank.
package otlm_pkg;

  typedef logic [7:0] otlm_byte_t;

  typedef logic [4:0] otlm_hyst_t;

  typedef logic [2:0] otlm_evset_t;

  typedef enum logic [2:0] {
    OTLM_CH_LOCAL       = 3'b000,
    OTLM_CH_R1_FIRST    = 3'b001,
    OTLM_CH_R2_FIRST    = 3'b010,
    OTLM_CH_R1_SHARED   = 3'b011,
    OTLM_CH_R2_SHARED   = 3'b100
  } otlm_chan_t;

endpackage : otlm_pkg

// *** rtl/otlm_hyst_cmp.sv ***
// One channel comparator with a set threshold and a hysteresis-lowered clear threshold.
`timescale 1ns/1ps
`include "otlm_map.svh"

module otlm_hyst_cmp (
  input  wire logic                i_mclk,
  input  wire logic                i_arst_n,
  input  wire logic                i_sample,
  input  wire otlm_pkg::otlm_byte_t i_temp,
  input  wire otlm_pkg::otlm_byte_t i_limit,
  input  wire otlm_pkg::otlm_hyst_t i_hyst,
  output logic                     o_event
);

  logic       event_q;
  logic       next_event;
  logic [8:0] temp_plus_hyst;

  always_comb begin
    temp_plus_hyst = {1'b0, i_temp} + {4'b0000, i_hyst};
    next_event     = event_q;
    if (i_sample) begin
      if (i_temp >= i_limit) begin
        next_event = 1'b1;
      end else if (temp_plus_hyst < {1'b0, i_limit}) begin
        next_event = 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      event_q <= 1'b0;
    end else begin
      event_q <= next_event;
    end
  end

  assign o_event = event_q;

endmodule : otlm_hyst_cmp

// *** rtl/otlm_pin_drive.sv ***
// Masks three channel events, ORs them and drives one active-low open-drain output.
`timescale 1ns/1ps

module otlm_pin_drive (
  input  wire logic                 i_mclk,
  input  wire logic                 i_arst_n,
  input  wire otlm_pkg::otlm_evset_t i_events,
  input  wire otlm_pkg::otlm_evset_t i_block,
  output logic                      o_pin_out,
  output logic                      o_pin_oe,
  output logic                      o_asserted
);

  logic asserted_q;
  logic next_asserted;

  always_comb begin
    next_asserted = |(i_events & ~i_block);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      asserted_q <= 1'b0;
    end else begin
      asserted_q <= next_asserted;
    end
  end

  assign o_pin_out  = 1'b0;
  assign o_pin_oe   = asserted_q;
  assign o_asserted = asserted_q;

endmodule : otlm_pin_drive

// *** rtl/otlm_regs.sv ***
// Over-temperature limit, hysteresis, mask and identity register bank with three open-drain outputs.
// Operation
// - Mask bit 2 of the third output blocks the remote-two event from that output, and 0 lets it pass.
// - Mask bit 1 of the third output blocks the remote-one event from that output, and 0 lets it pass.
// - Mask bit 0 of the third output blocks the local event from that output, and 0 lets it pass.
// - The upper five bits of the third output mask always read zero.
// - The third output mask sits at command 0x0E and resets with all three events blocked.
// - The local limit holds 0 to 127 degrees, its top bit reads zero, and it resets to 0x55.
// - The local limit is the threshold of the local error event.
// - Each remote limit is a full read-write byte of whole degrees from 0 to 255.
// - The first output remote limits sit at 0x41 and 0x42, reset to 110 degrees and feed only that output.
// - The shared remote limits at 0x49 and 0x4A serve the second and third outputs and reset to 85 degrees.
// - All outputs share the single local limit, the first uses its own remote limits, the others the shared ones.
// - A common hysteresis is subtracted from every limit when the temperature is falling, resetting to ten degrees.
// - The hysteresis keeps five writable bits and its upper three bits read zero.
// - An event sets at or above its limit and clears only below the limit minus the hysteresis.
`timescale 1ns/1ps
`include "otlm_map.svh"

module otlm_regs #(
  parameter logic [7:0] MAKER_CODE    = 8'h5A, // Arbitrary value.
  parameter logic [7:0] REVISION_CODE = 8'h3C  // Arbitrary value.
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_arst_n,
  input  wire otlm_pkg::otlm_byte_t  i_cmd,
  input  wire logic                 i_wr_en,
  input  wire otlm_pkg::otlm_byte_t  i_wr_data,
  input  wire logic                 i_rd_en,
  output otlm_pkg::otlm_byte_t       o_rd_data,
  output logic                      o_rd_valid,
  input  wire logic                 i_conv_done,
  input  wire otlm_pkg::otlm_byte_t  i_local_temp,
  input  wire otlm_pkg::otlm_byte_t  i_remote_one_temp,
  input  wire otlm_pkg::otlm_byte_t  i_remote_two_temp,
  input  wire logic                 i_overtemp_out_first_in,
  output logic                      o_overtemp_out_first_out,
  output logic                      o_overtemp_out_first_oe,
  input  wire logic                 i_overtemp_out_second_in,
  output logic                      o_overtemp_out_second_out,
  output logic                      o_overtemp_out_second_oe,
  input  wire logic                 i_overtemp_out_third_in,
  output logic                      o_overtemp_out_third_out,
  output logic                      o_overtemp_out_third_oe,
  output logic [4:0]                o_channel_events
);

  // Configuration registers.
  otlm_pkg::otlm_evset_t first_mask;
  otlm_pkg::otlm_evset_t second_mask;
  otlm_pkg::otlm_evset_t third_mask;
  logic [6:0]            local_limit;
  otlm_pkg::otlm_byte_t  remote_one_first_limit;
  otlm_pkg::otlm_byte_t  remote_two_first_limit;
  otlm_pkg::otlm_byte_t  remote_one_shared_limit;
  otlm_pkg::otlm_byte_t  remote_two_shared_limit;
  otlm_pkg::otlm_hyst_t  common_hysteresis;

  otlm_pkg::otlm_evset_t next_first_mask;
  otlm_pkg::otlm_evset_t next_second_mask;
  otlm_pkg::otlm_evset_t next_third_mask;
  logic [6:0]            next_local_limit;
  otlm_pkg::otlm_byte_t  next_remote_one_first_limit;
  otlm_pkg::otlm_byte_t  next_remote_two_first_limit;
  otlm_pkg::otlm_byte_t  next_remote_one_shared_limit;
  otlm_pkg::otlm_byte_t  next_remote_two_shared_limit;
  otlm_pkg::otlm_hyst_t  next_common_hysteresis;

  // Read port state.
  otlm_pkg::otlm_byte_t  rd_data;
  logic                  rd_valid;
  otlm_pkg::otlm_byte_t  next_rd_data;
  logic                  next_rd_valid;

  // Command decode.
  logic wr_first_mask;
  logic wr_second_mask;
  logic wr_third_mask;
  logic wr_local_limit;
  logic wr_r1_first;
  logic wr_r2_first;
  logic wr_r1_shared;
  logic wr_r2_shared;
  logic wr_hysteresis;

  // Channel comparator plumbing.
  otlm_pkg::otlm_byte_t  chan_temp  [`OTLM_NUM_CHANNELS];
  otlm_pkg::otlm_byte_t  chan_limit [`OTLM_NUM_CHANNELS];
  logic [4:0]            chan_event;
  otlm_pkg::otlm_evset_t first_events;
  otlm_pkg::otlm_evset_t shared_events;
  otlm_pkg::otlm_byte_t  local_limit_byte;

  always_comb begin
    wr_first_mask  = i_wr_en && (i_cmd == `OTLM_CMD_FIRST_MASK);
    wr_second_mask = i_wr_en && (i_cmd == `OTLM_CMD_SECOND_MASK);
    wr_third_mask  = i_wr_en && (i_cmd == `OTLM_CMD_THIRD_MASK);
    wr_local_limit = i_wr_en && (i_cmd == `OTLM_CMD_LOCAL_LIMIT);
    wr_r1_first    = i_wr_en && (i_cmd == `OTLM_CMD_R1_FIRST_LIMIT);
    wr_r2_first    = i_wr_en && (i_cmd == `OTLM_CMD_R2_FIRST_LIMIT);
    wr_r1_shared   = i_wr_en && (i_cmd == `OTLM_CMD_R1_SHARED_LIMIT);
    wr_r2_shared   = i_wr_en && (i_cmd == `OTLM_CMD_R2_SHARED_LIMIT);
    wr_hysteresis  = i_wr_en && (i_cmd == `OTLM_CMD_HYSTERESIS);
  end

  // Write path: each register keeps only its implemented bits; identity commands have no write decode.
  always_comb begin
    next_first_mask              = first_mask;
    next_second_mask             = second_mask;
    next_third_mask              = third_mask;
    next_local_limit             = local_limit;
    next_remote_one_first_limit  = remote_one_first_limit;
    next_remote_two_first_limit  = remote_two_first_limit;
    next_remote_one_shared_limit = remote_one_shared_limit;
    next_remote_two_shared_limit = remote_two_shared_limit;
    next_common_hysteresis       = common_hysteresis;
    if (wr_first_mask) begin
      next_first_mask = i_wr_data[2:0];
    end
    if (wr_second_mask) begin
      next_second_mask = i_wr_data[2:0];
    end
    if (wr_third_mask) begin
      next_third_mask = i_wr_data[2:0];
    end
    if (wr_local_limit) begin
      next_local_limit = i_wr_data[6:0];
    end
    if (wr_r1_first) begin
      next_remote_one_first_limit = i_wr_data;
    end
    if (wr_r2_first) begin
      next_remote_two_first_limit = i_wr_data;
    end
    if (wr_r1_shared) begin
      next_remote_one_shared_limit = i_wr_data;
    end
    if (wr_r2_shared) begin
      next_remote_two_shared_limit = i_wr_data;
    end
    if (wr_hysteresis) begin
      next_common_hysteresis = i_wr_data[4:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_mask              <= 3'(`OTLM_RST_FIRST_MASK);
      second_mask             <= 3'(`OTLM_RST_SECOND_MASK);
      third_mask              <= 3'(`OTLM_RST_THIRD_MASK);
      local_limit             <= 7'(`OTLM_RST_LOCAL_LIMIT);
      remote_one_first_limit  <= `OTLM_RST_FIRST_LIMIT;
      remote_two_first_limit  <= `OTLM_RST_FIRST_LIMIT;
      remote_one_shared_limit <= `OTLM_RST_SHARED_LIMIT;
      remote_two_shared_limit <= `OTLM_RST_SHARED_LIMIT;
      common_hysteresis       <= 5'(`OTLM_RST_HYSTERESIS);
    end else begin
      first_mask              <= next_first_mask;
      second_mask             <= next_second_mask;
      third_mask              <= next_third_mask;
      local_limit             <= next_local_limit;
      remote_one_first_limit  <= next_remote_one_first_limit;
      remote_two_first_limit  <= next_remote_two_first_limit;
      remote_one_shared_limit <= next_remote_one_shared_limit;
      remote_two_shared_limit <= next_remote_two_shared_limit;
      common_hysteresis       <= next_common_hysteresis;
    end
  end

  // Read path: unimplemented bits and unmapped commands return zero.
  always_comb begin
    next_rd_data  = rd_data;
    next_rd_valid = i_rd_en;
    if (i_rd_en) begin
      unique case (i_cmd)
        `OTLM_CMD_FIRST_MASK: begin
          next_rd_data = {5'b0_0000, first_mask};
        end
        `OTLM_CMD_SECOND_MASK: begin
          next_rd_data = {5'b0_0000, second_mask};
        end
        `OTLM_CMD_THIRD_MASK: begin
          next_rd_data = {5'b0_0000, third_mask};
        end
        `OTLM_CMD_LOCAL_LIMIT: begin
          next_rd_data = {1'b0, local_limit};
        end
        `OTLM_CMD_R1_FIRST_LIMIT: begin
          next_rd_data = remote_one_first_limit;
        end
        `OTLM_CMD_R2_FIRST_LIMIT: begin
          next_rd_data = remote_two_first_limit;
        end
        `OTLM_CMD_R1_SHARED_LIMIT: begin
          next_rd_data = remote_one_shared_limit;
        end
        `OTLM_CMD_R2_SHARED_LIMIT: begin
          next_rd_data = remote_two_shared_limit;
        end
        `OTLM_CMD_HYSTERESIS: begin
          next_rd_data = {3'b000, common_hysteresis};
        end
        `OTLM_CMD_MAKER_ID: begin
          next_rd_data = MAKER_CODE;
        end
        `OTLM_CMD_DIE_REV: begin
          next_rd_data = REVISION_CODE;
        end
        default: begin
          next_rd_data = `OTLM_READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_data  <= `OTLM_READ_UNMAPPED;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  assign o_rd_data  = rd_data;
  assign o_rd_valid = rd_valid;

  // Channel map: the single local comparator feeds every output.
  always_comb begin
    local_limit_byte                         = {1'b0, local_limit};
    chan_temp[otlm_pkg::OTLM_CH_LOCAL]       = i_local_temp;
    chan_limit[otlm_pkg::OTLM_CH_LOCAL]      = local_limit_byte;
    chan_temp[otlm_pkg::OTLM_CH_R1_FIRST]    = i_remote_one_temp;
    chan_limit[otlm_pkg::OTLM_CH_R1_FIRST]   = remote_one_first_limit;
    chan_temp[otlm_pkg::OTLM_CH_R2_FIRST]    = i_remote_two_temp;
    chan_limit[otlm_pkg::OTLM_CH_R2_FIRST]   = remote_two_first_limit;
    chan_temp[otlm_pkg::OTLM_CH_R1_SHARED]   = i_remote_one_temp;
    chan_limit[otlm_pkg::OTLM_CH_R1_SHARED]  = remote_one_shared_limit;
    chan_temp[otlm_pkg::OTLM_CH_R2_SHARED]   = i_remote_two_temp;
    chan_limit[otlm_pkg::OTLM_CH_R2_SHARED]  = remote_two_shared_limit;
  end

  genvar g_ch;
  generate
    for (g_ch = 0; g_ch < `OTLM_NUM_CHANNELS; g_ch = g_ch + 1) begin : g_chan
      otlm_hyst_cmp u_cmp (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_sample (i_conv_done),
        .i_temp   (chan_temp[g_ch]),
        .i_limit  (chan_limit[g_ch]),
        .i_hyst   (common_hysteresis),
        .o_event  (chan_event[g_ch])
      );
    end
  endgenerate

  // Event sets per output, ordered remote two, remote one, local.
  always_comb begin
    first_events  = {chan_event[otlm_pkg::OTLM_CH_R2_FIRST],
                     chan_event[otlm_pkg::OTLM_CH_R1_FIRST],
                     chan_event[otlm_pkg::OTLM_CH_LOCAL]};
    shared_events = {chan_event[otlm_pkg::OTLM_CH_R2_SHARED],
                     chan_event[otlm_pkg::OTLM_CH_R1_SHARED],
                     chan_event[otlm_pkg::OTLM_CH_LOCAL]};
  end

  otlm_pin_drive u_first_pin (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_events   (first_events),
    .i_block    (first_mask),
    .o_pin_out  (o_overtemp_out_first_out),
    .o_pin_oe   (o_overtemp_out_first_oe),
    .o_asserted ()
  );

  otlm_pin_drive u_second_pin (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_events   (shared_events),
    .i_block    (second_mask),
    .o_pin_out  (o_overtemp_out_second_out),
    .o_pin_oe   (o_overtemp_out_second_oe),
    .o_asserted ()
  );

  // Bit 2 blocks remote two, bit 1 remote one, bit 0 local.
  otlm_pin_drive u_third_pin (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_events   (shared_events),
    .i_block    (third_mask),
    .o_pin_out  (o_overtemp_out_third_out),
    .o_pin_oe   (o_overtemp_out_third_oe),
    .o_asserted ()
  );

  assign o_channel_events = chan_event;

endmodule : otlm_regs

// *** tb/otlm_regs_monitor.sv ***
// Concurrent checks on the ports of the over-temperature register bank.
`timescale 1ns/1ps
`include "otlm_map.svh"

module otlm_regs_monitor (
  input wire logic                 i_mclk,
  input wire logic                 i_arst_n,
  input wire otlm_pkg::otlm_byte_t i_cmd,
  input wire logic                 i_wr_en,
  input wire otlm_pkg::otlm_byte_t i_wr_data,
  input wire logic                 i_rd_en,
  input wire otlm_pkg::otlm_byte_t o_rd_data,
  input wire logic                 o_rd_valid,
  input wire logic                 i_conv_done,
  input wire otlm_pkg::otlm_byte_t i_local_temp,
  input wire logic                 o_overtemp_out_first_oe,
  input wire logic                 o_overtemp_out_second_oe,
  input wire logic                 o_overtemp_out_third_oe,
  input wire logic [4:0]           o_channel_events
);
  otlm_pkg::otlm_byte_t lim, hyst, m1, m2, m3;
  logic [2:0]           exp_oe;
  logic [8:0]           lo_sum;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Shadow copies of the registers that the checks depend on.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lim  <= `OTLM_RST_LOCAL_LIMIT;
      hyst <= `OTLM_RST_HYSTERESIS;
      m1   <= `OTLM_RST_FIRST_MASK;
      m2   <= `OTLM_RST_SECOND_MASK;
      m3   <= `OTLM_RST_THIRD_MASK;
    end else if (i_wr_en) begin
      case (i_cmd)
        `OTLM_CMD_LOCAL_LIMIT: lim <= i_wr_data & `OTLM_LOCAL_LIMIT_BITS;
        `OTLM_CMD_HYSTERESIS:  hyst <= i_wr_data & `OTLM_HYST_BITS;
        `OTLM_CMD_FIRST_MASK:  m1 <= i_wr_data & `OTLM_MASK_BITS;
        `OTLM_CMD_SECOND_MASK: m2 <= i_wr_data & `OTLM_MASK_BITS;
        `OTLM_CMD_THIRD_MASK:  m3 <= i_wr_data & `OTLM_MASK_BITS;
        default: ;
      endcase
    end
  end

  always_comb begin
    exp_oe[0] = |(o_channel_events[2:0] & ~m1[2:0]);
    exp_oe[1] = |({o_channel_events[4:3], o_channel_events[0]} & ~m2[2:0]);
    exp_oe[2] = |({o_channel_events[4:3], o_channel_events[0]} & ~m3[2:0]);
    lo_sum    = {1'b0, i_local_temp} + {4'h0, hyst[4:0]};
  end

  sequence s_rd(c);
    i_rd_en && i_cmd == c;
  endsequence

  sequence s_stable_in(m);
    $stable(m) && $stable(o_channel_events);
  endsequence

  a_read_valid_once: assert property (i_rd_en ##1 !i_rd_en |-> o_rd_valid ##1 !o_rd_valid)
    else $error("read answer pulse wrong");
  a_mask_upper_zero: assert property (s_rd(`OTLM_CMD_THIRD_MASK) |=> o_rd_data[7:3] == 5'h00)
    else $error("third mask upper bits not zero");
  a_limit_top_zero: assert property (s_rd(`OTLM_CMD_LOCAL_LIMIT) |=> !o_rd_data[7])
    else $error("local limit top bit not zero");
  a_hyst_upper_zero: assert property (s_rd(`OTLM_CMD_HYSTERESIS) |=> o_rd_data[7:5] == 3'h0)
    else $error("hysteresis upper bits not zero");
  a_local_event_set: assert property (i_conv_done && i_local_temp >= lim |=> o_channel_events[0])
    else $error("local event not set at limit");
  a_local_event_clr: assert property (i_conv_done && lo_sum < {1'b0, lim} |=> !o_channel_events[0])
    else $error("local event not cleared below band");
  a_events_hold: assert property (!i_conv_done |=> $stable(o_channel_events))
    else $error("events changed without a sample");
  a_first_pin_mask: assert property (s_stable_in(m1) |=> o_overtemp_out_first_oe == $past(exp_oe[0]))
    else $error("first output disagrees with masked events");
  a_second_pin_mask: assert property (s_stable_in(m2) |=> o_overtemp_out_second_oe == $past(exp_oe[1]))
    else $error("second output disagrees with masked events");
  a_third_pin_mask: assert property (s_stable_in(m3) |=> o_overtemp_out_third_oe == $past(exp_oe[2]))
    else $error("third output disagrees with masked events");
endmodule : otlm_regs_monitor

bind otlm_regs otlm_regs_monitor mon_u (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cmd(i_cmd), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_conv_done(i_conv_done),
  .i_local_temp(i_local_temp), .o_overtemp_out_first_oe(o_overtemp_out_first_oe),
  .o_overtemp_out_second_oe(o_overtemp_out_second_oe), .o_overtemp_out_third_oe(o_overtemp_out_third_oe),
  .o_channel_events(o_channel_events)
);

// *** tb/otlm_host_model.sv ***
// Host controller model that writes and reads the register bank by command byte.
`timescale 1ns/1ps

module otlm_host_model (
  input  wire logic                 i_mclk,
  output otlm_pkg::otlm_byte_t      o_cmd,
  output logic                      o_wr_en,
  output otlm_pkg::otlm_byte_t      o_wr_data,
  output logic                      o_rd_en,
  input  wire otlm_pkg::otlm_byte_t i_rd_data,
  input  wire logic                 i_rd_valid
);
  initial begin
    o_cmd = 8'h00;
    o_wr_en = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en = 1'b0;
  end

  task automatic write(input otlm_pkg::otlm_byte_t cmd, input otlm_pkg::otlm_byte_t data);
    @(posedge i_mclk);
    o_cmd     <= cmd;
    o_wr_data <= data;
    o_wr_en   <= 1'b1;
    @(posedge i_mclk);
    o_wr_en   <= 1'b0;
    o_cmd     <= ~cmd;
    o_wr_data <= ~data;
  endtask : write

  task automatic read(input otlm_pkg::otlm_byte_t cmd, output otlm_pkg::otlm_byte_t data, output bit ok);
    ok = 1'b0;
    data = 8'h00;
    @(posedge i_mclk);
    o_cmd   <= cmd;
    o_rd_en <= 1'b1;
    @(posedge i_mclk);
    o_rd_en <= 1'b0;
    o_cmd   <= ~cmd;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge i_mclk);
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        data = i_rd_data;
      end
    end
  endtask : read
endmodule : otlm_host_model

// *** tb/overtemp_limit_mask_regs_bench.sv ***
// Self-checking bench for the over-temperature register bank.
`timescale 1ns/1ps

module overtemp_limit_mask_regs_bench;
  // Both identity values are arbitrary.
  localparam logic [7:0] MAKER = 8'hA6;
  localparam logic [7:0] REV   = 8'h3D;

  logic                 i_mclk = 1'b0;
  logic                 i_arst_n = 1'b0;
  otlm_pkg::otlm_byte_t cmd, wr_data, rd_data, l_temp, r1_temp, r2_temp;
  logic                 wr_en, rd_en, rd_valid, conv_done, oe1, oe2, oe3, out1, out2, out3;
  logic [4:0]           events;
  int                   fail_count = 0;
  int                   checks = 0;
  int                   cycles = 0;
  logic [31:0]          seed = 32'h0000_1543;
  int                   mdl[256];
  int                   wmask[256];
  int                   ev[5];
  int                   addrs[$] = '{8'h0C, 8'h0D, 8'h0E, 8'h40, 8'h41, 8'h42, 8'h49, 8'h4A, 8'h5A, 8'hFE, 8'hFF, 8'h10};
  int                   rst_q[$] = '{8'h01, 8'h00, 8'h07, 8'h55, 8'h6E, 8'h6E, 8'h55, 8'h55, 8'h0A, MAKER, REV, 8'h00};
  int                   wm_q[$] = '{8'h07, 8'h07, 8'h07, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h1F, 8'h00, 8'h00, 8'h00};
  int                   hq[$] = '{8'h30, 8'h2B, 8'h2A, 8'h2F, 8'h30};
  wire logic            pin1 = ~oe1;
  wire logic            pin2 = ~oe2;
  wire logic            pin3 = ~oe3;

  always #4 i_mclk = ~i_mclk;

  otlm_regs #(.MAKER_CODE(MAKER), .REVISION_CODE(REV)) dut_u (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cmd(cmd), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .i_rd_en(rd_en), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_conv_done(conv_done),
    .i_local_temp(l_temp), .i_remote_one_temp(r1_temp), .i_remote_two_temp(r2_temp),
    .i_overtemp_out_first_in(pin1), .o_overtemp_out_first_out(out1), .o_overtemp_out_first_oe(oe1),
    .i_overtemp_out_second_in(pin2), .o_overtemp_out_second_out(out2), .o_overtemp_out_second_oe(oe2),
    .i_overtemp_out_third_in(pin3), .o_overtemp_out_third_out(out3), .o_overtemp_out_third_oe(oe3),
    .o_channel_events(events)
  );

  otlm_host_model host_u (
    .i_mclk(i_mclk), .o_cmd(cmd), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en),
    .i_rd_data(rd_data), .i_rd_valid(rd_valid)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic int near(input int lim);
    return lim - 16 + int'(xs() % 32);
  endfunction : near

  function automatic logic pin(input int m, input int r2, input int r1, input int lo);
    return |({r2[0], r1[0], lo[0]} & ~m[2:0]);
  endfunction : pin

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic wr(input int a, input int d);
    host_u.write(8'(a), 8'(d));
    if (wmask[a] != 0) mdl[a] = d & wmask[a];
  endtask : wr

  task automatic rd(input int a);
    otlm_pkg::otlm_byte_t got;
    bit ok;
    host_u.read(8'(a), got, ok);
    check({7'h00, ok}, 8'h01);
    check(got, 8'(mdl[a]));
  endtask : rd

  task automatic conv(input int l, input int a, input int b);
    int t[5];
    int lim[5];
    t = '{l, a, b, a, b};
    lim = '{mdl[8'h40], mdl[8'h41], mdl[8'h42], mdl[8'h49], mdl[8'h4A]};
    @(posedge i_mclk);
    l_temp <= 8'(l);
    r1_temp <= 8'(a);
    r2_temp <= 8'(b);
    conv_done <= 1'b1;
    @(posedge i_mclk);
    conv_done <= 1'b0;
    foreach (ev[i]) begin
      if (t[i] >= lim[i]) ev[i] = 1;
      else if (t[i] + mdl[8'h5A] < lim[i]) ev[i] = 0;
    end
    repeat (2) @(posedge i_mclk);
    check({3'h0, events}, 8'(ev[4] * 16 + ev[3] * 8 + ev[2] * 4 + ev[1] * 2 + ev[0]));
    check({5'h00, oe3, oe2, oe1}, {5'h00, pin(mdl[8'h0E], ev[4], ev[3], ev[0]),
          pin(mdl[8'h0D], ev[4], ev[3], ev[0]), pin(mdl[8'h0C], ev[2], ev[1], ev[0])});
    check({5'h00, out3, out2, out1}, 8'h00);
  endtask : conv

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  initial begin
    l_temp = 8'h00;
    r1_temp = 8'h00;
    r2_temp = 8'h00;
    conv_done = 1'b0;
    foreach (addrs[i]) begin
      mdl[addrs[i]] = rst_q[i];
      wmask[addrs[i]] = wm_q[i];
    end
    repeat (16) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    foreach (addrs[i]) rd(addrs[i]);
    foreach (addrs[i]) begin
      wr(addrs[i], 8'hFF);
      rd(addrs[i]);
      wr(addrs[i], int'(xs() & 32'h0000_00FF));
      rd(addrs[i]);
    end
    wr(8'h40, 8'h30);
    wr(8'h41, 8'h50);
    wr(8'h42, 8'h60);
    wr(8'h49, 8'h40);
    wr(8'h4A, 8'h45);
    wr(8'h5A, 8'h05);
    for (int e = 0; e < 8; e++) begin
      for (int m = 0; m < 8; m++) begin
        wr(8'h0E, m);
        wr(8'h0D, 7 - m);
        wr(8'h0C, m ^ 5);
        conv(e[0] ? 8'h30 : 0, e[1] ? 8'h50 : 0, e[2] ? 8'h60 : 0);
      end
    end
    foreach (hq[i]) conv(hq[i], 0, 0);
    repeat (60) begin
      wr(8'h0C + int'(xs() % 3), int'(xs() & 32'h0000_00FF));
      conv(near(8'h30), near(8'h48), near(8'h52));
    end
    results();
  end
endmodule : overtemp_limit_mask_regs_bench
